// file: rtl/txd_pkg.sv
// Purpose: Shared constants for the transmit descriptor fetch engine.
// Assumes: Little-endian Dword layout of command blocks and descriptors in host memory.
// Notes:   Byte offsets are APB byte addresses; bit positions are within 32-bit words.
package txd_pkg;
    // APB register byte offsets.
    localparam logic [7:0]  CTRL_OFF      = 8'h00;
    localparam logic [7:0]  CBADDR_OFF    = 8'h04;
    localparam logic [7:0]  STATUS_OFF    = 8'h08;
    localparam logic [7:0]  UNDERRUN_OFF  = 8'h0c;
    localparam logic [7:0]  FRAMES_OFF    = 8'h10;
    // Control register bit positions.
    localparam int          CTRL_START    = 0;
    localparam int          CTRL_EXT      = 1;
    localparam int          CTRL_DYN      = 2;
    localparam int          CTRL_LEGACY   = 3;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    // Command block status and command word.
    localparam int          STAT_C        = 15;
    localparam int          STAT_OK       = 13;
    localparam int          STAT_U        = 12;
    localparam int          CMD_LAYOUT    = 19;
    // Command block word 3 fields.
    localparam int          IMM_LSB       = 0;
    localparam int          IMM_W         = 14;
    localparam int          EOF_BIT       = 15;
    localparam int          THR_LSB       = 16;
    localparam int          NUM_LSB       = 24;
    // Buffer descriptor control word.
    localparam int          DESC_EL       = 16;
    localparam int          SIZE_W        = 14;
    // Memory layout figures.
    localparam logic [31:0] NULL_PTR      = 32'hffff_ffff;
    localparam logic [31:0] IMM_OFF       = 32'h0000_0010;
    localparam logic [31:0] ARRAY_OFF     = 32'h0000_0008;
    localparam logic [3:0]  STD_WORDS     = 4'h4;
    localparam logic [3:0]  EXT_WORDS     = 4'h8;
    localparam logic [3:0]  DESC_WORDS    = 4'h2;
    localparam logic [7:0]  EMBEDDED_DESC = 8'h02;
    localparam logic [7:0]  DYN_COUNT     = 8'hff;
    localparam int          THR_SHIFT     = 3;
    localparam int          MAX_IMM       = 2600;

    typedef enum logic [2:0] {
        S_IDLE, S_FETCH, S_IMM, S_NEXT, S_TBD, S_CHECK, S_BUF, S_STATUS
    } state_e;
endpackage

// file: rtl/transmit_descriptor_fetch.sv
// Purpose: Fetches a transmit command block and its buffer descriptors, hands the
//          immediate data and each buffer to the transmit data mover, gates the wire
//          start on the FIFO threshold and writes the status word back once.
// Assumes: Memory and data mover ports are on ref_clk; software starts one block at a time.
// Notes:   Statistics counters are readable over APB and never written to memory.
// How it works
// - Completion bit 15 is written once DMA has moved the last byte, before wire end.
// - Wire completion bumps the frame counter and clears wire start, never writes the command block.
// - Success bit 13 is always written together with completion.
// - Underrun bit 12 reports underruns up to the write-back request; counter increments on every one.
// - Flexible layout uses the array pointer; simplified layout carries all-ones.
// - Descriptor N sits at array plus N*8, its control word at N*8+4.
// - A zero descriptor count means no descriptors at all.
// - Older generation ends the frame on the descriptor count only.
// - Wire start waits for threshold times 8 bytes in the transmit FIFO.
// - The whole-frame flag is ignored by the hardware.
// - Immediate data is read from block offset 10h for a 14-bit count.
// - Any immediate count up to 2600, odd included, is moved unchanged.
// - Simplified layout takes the full frame from the immediate count.
// - Flexible layout with zero immediate count takes all data from buffers.
// - Extended blocks are fetched as one 8-Dword burst instead of 4.
// - In extended blocks the array pointer addresses the third descriptor.
// - In extended blocks the count includes the two embedded descriptors.
// - Extended blocks are always flexible; embedded pointers are nonzero.
// - The layout select bit picks simplified or flexible layout.
// - Newer generations end the frame at a descriptor with its last flag.
// - In dynamic mode a zero buffer pointer is dropped and re-read.
module transmit_descriptor_fetch
    import txd_pkg::*;
#(
    parameter int FIFO_W = 12
) (
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   memReq,
    output logic                   memWrite,
    output logic      [31:0]       memAddr,
    output logic      [3:0]        memLen,
    output logic      [31:0]       memWdata,
    input  wire logic              memRvalid,
    input  wire logic [31:0]       memRdata,
    input  wire logic              memAck,
    output logic                   dmaReq,
    output logic      [31:0]       dmaAddr,
    output logic      [IMM_W-1:0]  dmaLen,
    input  wire logic              dmaDone,
    input  wire logic [FIFO_W-1:0] fifoLevel,
    output logic                   txStart,
    input  wire logic              underrunIn,
    input  wire logic              wireDoneIn
);
    typedef struct packed {
        state_e             state;
        logic               pready;
        logic [31:0]        prdata;
        logic               pslverr;
        logic               cfgExt;
        logic               cfgDyn;
        logic               cfgLegacy;
        logic [31:0]        cbAddr;
        logic [7:0][31:0]   words;
        logic [3:0]         wordCnt;
        logic               memReq;
        logic               memWrite;
        logic [31:0]        memAddr;
        logic [3:0]         memLen;
        logic [31:0]        memWdata;
        logic               dmaReq;
        logic [31:0]        dmaAddr;
        logic [IMM_W-1:0]   dmaLen;
        logic [7:0]         idx;
        logic               doneDesc;
        logic               lastDesc;
        logic               embedded;
        logic [31:0]        dPtr;
        logic [31:0]        dCtl;
        logic               underrunPend;
        logic [15:0]        underrunCount;
        logic [15:0]        frameCount;
        logic               frameLive;
        logic               txStart;
    } state_s;

    state_s r;
    state_s next_r;

    logic             flexible;
    logic             noDesc;
    logic [7:0]       descCount;
    logic [7:0]       threshold;
    logic [IMM_W-1:0] immCount;
    logic [7:0]       arrayIdx;
    logic [FIFO_W:0]  thrBytes;

    always_comb begin
        // Extended blocks are flexible regardless of the layout bit.
        flexible  = r.cfgExt || r.words[0][CMD_LAYOUT];
        descCount = r.words[3][NUM_LSB +: 8];
        threshold = r.words[3][THR_LSB +: 8];
        immCount  = r.words[3][IMM_LSB +: IMM_W];
        // The whole-frame flag is deliberately never read.
        noDesc    = !flexible || (descCount == 8'h00);
        // Embedded descriptors take the first two places of the count.
        arrayIdx  = r.cfgExt ? r.idx - EMBEDDED_DESC : r.idx;
        thrBytes  = (FIFO_W + 1)'({threshold, {THR_SHIFT{1'b0}}});
    end

    always_comb begin
        next_r = r;

        // APB slave: one wait state, answer registered.
        next_r.pready  = 1'b0;
        next_r.pslverr = 1'b0;
        if (psel && penable && !r.pready) begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0000_0000;
            if (paddr == CTRL_OFF) begin
                if (pwrite) begin
                    next_r.cfgExt    = pwdata[CTRL_EXT];
                    next_r.cfgDyn    = pwdata[CTRL_DYN];
                    next_r.cfgLegacy = pwdata[CTRL_LEGACY];
                end else begin
                    next_r.prdata[CTRL_EXT]    = r.cfgExt;
                    next_r.prdata[CTRL_DYN]    = r.cfgDyn;
                    next_r.prdata[CTRL_LEGACY] = r.cfgLegacy;
                end
            end else if (paddr == CBADDR_OFF) begin
                if (pwrite) begin
                    next_r.cbAddr = pwdata;
                end else begin
                    next_r.prdata = r.cbAddr;
                end
            end else if (paddr == STATUS_OFF) begin
                next_r.prdata[0] = (r.state != S_IDLE);
                next_r.prdata[1] = r.frameLive;
                next_r.prdata[2] = r.underrunPend;
                next_r.prdata[3] = r.txStart;
            end else if (paddr == UNDERRUN_OFF) begin
                next_r.prdata[15:0] = r.underrunCount;
            end else if (paddr == FRAMES_OFF) begin
                next_r.prdata[15:0] = r.frameCount;
            end else begin
                next_r.pslverr = 1'b1;
            end
        end

        case (r.state)
            S_IDLE: begin
                if (psel && penable && !r.pready && pwrite && paddr == CTRL_OFF
                        && pwdata[CTRL_START]) begin
                    next_r.memReq    = 1'b1;
                    next_r.memWrite  = 1'b0;
                    next_r.memAddr   = r.cbAddr;
                    // Mode bits written together with start apply to this very block.
                    next_r.memLen    = pwdata[CTRL_EXT] ? EXT_WORDS : STD_WORDS;
                    next_r.wordCnt   = 4'h0;
                    next_r.idx       = 8'h00;
                    next_r.doneDesc  = 1'b0;
                    next_r.frameLive = 1'b1;
                    next_r.txStart   = 1'b0;
                    next_r.state     = S_FETCH;
                end
            end
            S_FETCH: begin
                if (memRvalid) begin
                    next_r.words[r.wordCnt[2:0]] = memRdata;
                    next_r.wordCnt = r.wordCnt + 4'h1;
                    if (r.wordCnt == r.memLen - 4'h1) begin
                        next_r.memReq = 1'b0;
                        next_r.state  = S_IMM;
                    end
                end
            end
            S_IMM: begin
                // Immediate data first; the count is moved as given, odd or not.
                if (!r.dmaReq && immCount != '0) begin
                    next_r.dmaReq  = 1'b1;
                    next_r.dmaAddr = r.cbAddr + IMM_OFF;
                    next_r.dmaLen  = immCount;
                end else if (!r.dmaReq) begin
                    next_r.state = S_NEXT;
                end else if (dmaDone) begin
                    next_r.dmaReq = 1'b0;
                    next_r.state  = S_NEXT;
                end
            end
            S_NEXT: begin
                if (noDesc || r.doneDesc) begin
                    next_r.state = S_STATUS;
                end else if (r.cfgExt && r.idx < EMBEDDED_DESC) begin
                    next_r.dPtr     = r.words[3'(4 + 2 * r.idx)];
                    next_r.dCtl     = r.words[3'(5 + 2 * r.idx)];
                    next_r.embedded = 1'b1;
                    next_r.state    = S_CHECK;
                end else begin
                    next_r.memReq   = 1'b1;
                    next_r.memWrite = 1'b0;
                    next_r.memAddr  = r.words[2] + ARRAY_OFF * 32'(arrayIdx);
                    next_r.memLen   = DESC_WORDS;
                    next_r.wordCnt  = 4'h0;
                    next_r.embedded = 1'b0;
                    next_r.state    = S_TBD;
                end
            end
            S_TBD: begin
                if (memRvalid) begin
                    next_r.wordCnt = r.wordCnt + 4'h1;
                    if (r.wordCnt == 4'h0) begin
                        next_r.dPtr = memRdata;
                    end else begin
                        next_r.dCtl   = memRdata;
                        next_r.memReq = 1'b0;
                        next_r.state  = S_CHECK;
                    end
                end
            end
            S_CHECK: begin
                if (r.cfgDyn && !r.embedded && r.dPtr == 32'h0000_0000) begin
                    // Invalid pointer: drop it and read the same slot again.
                    next_r.state = S_NEXT;
                end else begin
                    next_r.lastDesc = (r.idx + 8'h01 == descCount)
                        || (!r.cfgLegacy && r.dCtl[DESC_EL]);
                    if (r.dCtl[SIZE_W-1:0] != '0) begin
                        next_r.dmaReq  = 1'b1;
                        next_r.dmaAddr = r.dPtr;
                        next_r.dmaLen  = r.dCtl[SIZE_W-1:0];
                        next_r.state   = S_BUF;
                    end else begin
                        next_r.idx      = r.idx + 8'h01;
                        next_r.doneDesc = next_r.lastDesc;
                        next_r.state    = S_NEXT;
                    end
                end
            end
            S_BUF: begin
                if (dmaDone) begin
                    next_r.dmaReq   = 1'b0;
                    next_r.idx      = r.idx + 8'h01;
                    next_r.doneDesc = r.lastDesc;
                    next_r.state    = S_NEXT;
                end
            end
            S_STATUS: begin
                // All three flags leave in one Dword; the command half is kept.
                if (!r.memReq) begin
                    next_r.memReq   = 1'b1;
                    next_r.memWrite = 1'b1;
                    next_r.memAddr  = r.cbAddr;
                    next_r.memWdata = {r.words[0][31:16], 1'b1, 1'b0, 1'b1,
                                       r.underrunPend, 12'h000};
                end else if (memAck) begin
                    next_r.memReq       = 1'b0;
                    next_r.memWrite     = 1'b0;
                    next_r.underrunPend = 1'b0;
                    next_r.state        = S_IDLE;
                end
            end
            default: begin
                next_r.state = S_IDLE;
            end
        endcase

        // An underrun in the write-back cycle is kept for the next block.
        if (underrunIn) begin
            next_r.underrunPend  = 1'b1;
            next_r.underrunCount = r.underrunCount + 16'h0001;
        end
        // Wire completion bumps the frame counter and clears wire start, never touches memory.
        // A block started in the wire-end cycle keeps its own frame live.
        if (wireDoneIn) begin
            next_r.frameCount = r.frameCount + 16'h0001;
            next_r.frameLive  = (r.state == S_IDLE) && (next_r.state == S_FETCH);
            next_r.txStart    = 1'b0;
        end else if (r.frameLive && r.state != S_FETCH && next_r.state != S_FETCH
                && (FIFO_W + 1)'(fifoLevel) >= thrBytes) begin
            // The threshold word is stale until the block fetch has finished.
            next_r.txStart = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign prdata   = r.prdata;
    assign pready   = r.pready;
    assign pslverr  = r.pslverr;
    assign memReq   = r.memReq;
    assign memWrite = r.memWrite;
    assign memAddr  = r.memAddr;
    assign memLen   = r.memLen;
    assign memWdata = r.memWdata;
    assign dmaReq   = r.dmaReq;
    assign dmaAddr  = r.dmaAddr;
    assign dmaLen   = r.dmaLen;
    assign txStart  = r.txStart;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_status_flags: assert property (memReq && memWrite |-> memWdata[STAT_C]
        && memWdata[STAT_OK] && memWdata[11:0] == 12'h000)
        else $error("status write lacks completion or success");
    a_status_single: assert property (memReq && memWrite && memAck |=> !memReq ##1
        r.state == S_IDLE)
        else $error("status written more than once");
    a_underrun_flag: assert property ($rose(memReq) && memWrite
        |-> memWdata[STAT_U] == $past(r.underrunPend))
        else $error("pending underrun not reported");
    a_wire_quiet: assert property (r.state == S_IDLE && wireDoneIn |=> !memReq)
        else $error("wire completion caused a memory access");
    a_thr_start: assert property ($rose(txStart)
        |-> (FIFO_W + 1)'($past(fifoLevel)) >= thrBytes)
        else $error("transmit started below threshold");
    a_burst_len: assert property (r.state == S_FETCH && memReq
        |-> memLen == (r.cfgExt ? EXT_WORDS : STD_WORDS))
        else $error("wrong command block burst length");
    a_imm_addr: assert property (r.state == S_IMM && dmaReq
        |-> dmaAddr == r.cbAddr + IMM_OFF && dmaLen == immCount)
        else $error("immediate data address or count wrong");
    a_null_desc: assert property (r.state == S_NEXT && noDesc |=> r.state == S_STATUS)
        else $error("descriptors fetched with zero count");
    a_desc_addr: assert property ($rose(memReq) && r.state == S_TBD
        |-> memAddr == r.words[2] + ARRAY_OFF * 32'($past(arrayIdx)) && memLen == DESC_WORDS)
        else $error("descriptor fetched from wrong address");
    a_dyn_retry: assert property (r.state == S_CHECK && r.cfgDyn && !r.embedded
        && r.dPtr == 32'h0 |=> r.state == S_NEXT ##1 r.state == S_TBD)
        else $error("invalid descriptor not re-read");
endmodule

// file: tb/host_side_model.sv
// Purpose: Host memory and transmit data mover on the far side of the fetch engine.
// Assumes: Byte-addressed Dwords; a word never written reads back as its inverted address.
// Notes:   Random gaps give both prompt and slow answers; released read data is inverted.
module host_side_model (
    input  wire logic        ref_clk,
    input  wire logic        memReq,
    input  wire logic        memWrite,
    input  wire logic [31:0] memAddr,
    input  wire logic [3:0]  memLen,
    input  wire logic [31:0] memWdata,
    output logic             memRvalid,
    output logic      [31:0] memRdata,
    output logic             memAck,
    input  wire logic        dmaReq,
    output logic             dmaDone
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [logic [31:0]];
    logic [31:0] patchAddr = 32'h0;
    logic [31:0] patchVal  = 32'h0;
    logic        patchOn   = 1'b0;
    int unsigned gap;
    initial memRvalid = 1'b0;
    initial memRdata = 32'h0;
    initial memAck = 1'b0;
    initial dmaDone = 1'b0;
    always begin
        @(posedge ref_clk);
        if (memReq === 1'b1 && memWrite === 1'b1) begin
            repeat ($urandom_range(0, 3)) @(posedge ref_clk);
            memAck <= 1'b1;
            mem[memAddr] = memWdata;
            @(posedge ref_clk);
            memAck <= 1'b0;
        end else if (memReq === 1'b1) begin
            for (int k = 0; k < 32'(memLen); k++) begin
                gap = $urandom_range(0, 2);
                // Valid is only lowered when a gap follows, so it is never driven twice.
                if (gap != 0) begin
                    memRvalid <= 1'b0;
                    memRdata  <= ~memRdata;
                    repeat (gap) @(posedge ref_clk);
                end
                memRvalid <= 1'b1;
                memRdata  <= mem.exists(memAddr + 32'(4 * k)) ?
                             mem[memAddr + 32'(4 * k)] : ~(memAddr + 32'(4 * k));
                @(posedge ref_clk);
                // The host fills in a pointer only after the engine has seen it empty.
                if (patchOn && memAddr + 32'(4 * k) == patchAddr) begin
                    mem[patchAddr] = patchVal;
                    patchOn = 1'b0;
                end
            end
            memRvalid <= 1'b0;
            memRdata  <= ~memRdata;
        end
    end
    always begin
        @(posedge ref_clk);
        if (dmaReq === 1'b1) begin
            repeat ($urandom_range(0, 4)) @(posedge ref_clk);
            dmaDone <= 1'b1;
            @(posedge ref_clk);
            dmaDone <= 1'b0;
        end
    end
endmodule

// file: tb/tb.sv
// Purpose: Self-checking bench for the transmit descriptor fetch engine.
// Assumes: One block in flight; the wire side is driven by the bench itself.
// Notes:   Memory and mover requests are checked in order against two expectation queues.
module tb
    import txd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic w; logic [31:0] addr; logic [31:0] val;} ev_s;
    logic        ref_clk = 1'b0;
    logic        resetn, psel, penable, pwrite, memReq, memWrite, memRvalid, memAck;
    logic        pready, pslverr, dmaReq, dmaDone, txStart, underrunIn, wireDoneIn;
    logic [7:0]  paddr, thr;
    logic [31:0] pwdata, prdata, memAddr, memWdata, memRdata, dmaAddr, w0q, rdat;
    logic [3:0]  memLen;
    logic [13:0] dmaLen;
    logic [11:0] fifoLevel;
    logic        err, memReqQ = 1'b0, dmaReqQ = 1'b0;
    ev_s         memQ[$], dmaQ[$];
    int          errors = 0, n_checks = 0, cyc = 0, frames = 0;
    always #10 ref_clk = ~ref_clk;
    transmit_descriptor_fetch #(.FIFO_W(12)) transmit_descriptor_fetch_i (
        .ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
        .memLen(memLen), .memWdata(memWdata), .memRvalid(memRvalid), .memRdata(memRdata),
        .memAck(memAck), .dmaReq(dmaReq), .dmaAddr(dmaAddr), .dmaLen(dmaLen),
        .dmaDone(dmaDone), .fifoLevel(fifoLevel), .txStart(txStart),
        .underrunIn(underrunIn), .wireDoneIn(wireDoneIn));
    host_side_model host_side_model_i (
        .ref_clk(ref_clk), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
        .memLen(memLen), .memWdata(memWdata), .memRvalid(memRvalid), .memRdata(memRdata),
        .memAck(memAck), .dmaReq(dmaReq), .dmaDone(dmaDone));
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Any request with nothing expected, including one after the wire end, fails here.
    always @(posedge ref_clk) begin
        cyc++;
        memReqQ <= memReq;
        dmaReqQ <= dmaReq;
        if (memReq === 1'b1 && memReqQ !== 1'b1) begin
            chk(memQ.size() > 0 && memQ[0] === {memWrite, memAddr,
                memWrite ? memWdata : {28'h0, memLen}}, "memory request");
            if (memQ.size() > 0) void'(memQ.pop_front());
        end
        if (dmaReq === 1'b1 && dmaReqQ !== 1'b1) begin
            chk(dmaQ.size() > 0 && dmaQ[0] === {1'b0, dmaAddr, {18'h0, dmaLen}},
                "mover request");
            if (dmaQ.size() > 0) void'(dmaQ.pop_front());
        end
        if (cyc == 30000) begin
            errors++;
            conclude();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rdat = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic expR(input logic [31:0] a, input logic [3:0] n);
        memQ.push_back({1'b0, a, {28'h0, n}});
    endtask
    task automatic expD(input logic [31:0] a, input logic [13:0] n);
        dmaQ.push_back({1'b0, a, {18'h0, n}});
    endtask
    function automatic logic [31:0] w3f(input logic [7:0] n, input logic eof,
                                        input logic [13:0] imm);
        return {n, 8'($urandom_range(1, 224)), eof, 1'b0, imm};
    endfunction
    task automatic setb(input logic [31:0] cb, w0, w2, w3, input logic [3:0] n);
        host_side_model_i.mem[cb] = w0;
        host_side_model_i.mem[cb + 32'h8] = w2;
        host_side_model_i.mem[cb + 32'hc] = w3;
        w0q = w0;
        thr = w3[23:16];
        expR(cb, n);
    endtask
    task automatic desc(input logic [31:0] a, input logic [13:0] sz, input logic last,
                        input logic rd);
        logic [31:0] p;
        p = $urandom() | 32'h1;
        host_side_model_i.mem[a] = p;
        host_side_model_i.mem[a + 32'h4] = {15'h0, last, 2'b0, sz};
        if (rd) expR(a, DESC_WORDS);
        if (sz != 14'h0) expD(p, sz);
    endtask
    task automatic go(input logic [31:0] cb, input logic [3:0] mode, input logic u);
        fifoLevel <= 12'(thr * 8 - 1);
        memQ.push_back({1'b1, cb, w0q[31:16], 1'b1, 1'b0, 1'b1, u, 12'h0});
        apb(1'b1, CBADDR_OFF, cb);
        apb(1'b1, CTRL_OFF, {28'h0, mode} | 32'h1);
        if (u) begin
            underrunIn <= 1'b1;
            @(posedge ref_clk);
            underrunIn <= 1'b0;
        end
        do apb(1'b0, STATUS_OFF, 32'h0); while (rdat[0] !== 1'b0);
        chk(memQ.size() == 0 && dmaQ.size() == 0, "requests missing");
        chk(txStart === 1'b0, "wire start below threshold");
        fifoLevel <= 12'(thr * 8);
        repeat (3) @(posedge ref_clk);
        chk(txStart === 1'b1, "no wire start at threshold");
        wireDoneIn <= 1'b1;
        @(posedge ref_clk);
        wireDoneIn <= 1'b0;
        frames++;
        repeat (2) @(posedge ref_clk);
        chk(txStart === 1'b0, "wire start held after wire end");
        apb(1'b0, FRAMES_OFF, 32'h0);
        chk(rdat === 32'(frames), "frames counter");
    endtask
    initial begin
        {resetn, psel, penable, pwrite, underrunIn, wireDoneIn} = 6'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        fifoLevel = 12'h0;
        void'($urandom(49));
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int a = 0; a <= 16; a += 4) begin
            apb(1'b0, 8'(a), 32'h0);
            chk(rdat === CTRL_RESET && err === 1'b0, "reset value");
        end
        apb(1'b1, 8'h40, 32'hffff_ffff);
        chk(err === 1'b1, "unmapped write accepted");
        apb(1'b0, 8'h40, 32'h0);
        chk(err === 1'b1 && rdat === 32'h0, "unmapped read");
        setb(32'h1000, 32'h0004_0000, NULL_PTR, w3f(8'h0, 1'b1, 14'd13), STD_WORDS);
        expD(32'h1000 + IMM_OFF, 14'd13);
        go(32'h1000, 4'h0, 1'b1);
        setb(32'h2000, 32'h0004_0000, NULL_PTR, w3f(8'h0, 1'b1, 14'(MAX_IMM)), STD_WORDS);
        expD(32'h2000 + IMM_OFF, 14'(MAX_IMM));
        go(32'h2000, 4'h0, 1'b0);
        setb(32'h3000, 32'h000c_0000, 32'h3100, w3f(8'h2, 1'b0, 14'd6), STD_WORDS);
        expD(32'h3000 + IMM_OFF, 14'd6);
        desc(32'h3100, 14'($urandom_range(1, 1500)), 1'b0, 1'b1);
        desc(32'h3108, 14'($urandom_range(1, 1500)), 1'b0, 1'b1);
        go(32'h3000, 4'h0, 1'b0);
        for (int lg = 0; lg < 2; lg++) begin
            setb(32'h4000, 32'h000c_0000, 32'h4100, w3f(8'h3, 1'b1, 14'd0), STD_WORDS);
            desc(32'h4100, 14'($urandom_range(1, 1500)), 1'b0, 1'b1);
            desc(32'h4108, 14'($urandom_range(1, 1500)), 1'b1, 1'b1);
            if (lg == 1) desc(32'h4110, 14'($urandom_range(1, 1500)), 1'b0, 1'b1);
            go(32'h4000, lg == 1 ? 4'(1 << CTRL_LEGACY) : 4'h0, 1'b0);
        end
        setb(32'h5000, 32'h000c_0000, 32'h5100, w3f(8'h0, 1'b1, 14'd5), STD_WORDS);
        expD(32'h5000 + IMM_OFF, 14'd5);
        go(32'h5000, 4'h0, 1'b0);
        setb(32'h6000, 32'h0004_0000, 32'h6100, w3f(8'h3, 1'b1, 14'd0), EXT_WORDS);
        desc(32'h6010, 14'($urandom_range(1, 1500)), 1'b0, 1'b0);
        desc(32'h6018, 14'h0, 1'b0, 1'b0);
        desc(32'h6100, 14'($urandom_range(1, 1500)), 1'b0, 1'b1);
        go(32'h6000, 4'(1 << CTRL_EXT), 1'b0);
        setb(32'h7000, 32'h000c_0000, 32'h7100, w3f(DYN_COUNT, 1'b1, 14'd0), STD_WORDS);
        desc(32'h7100, 14'($urandom_range(1, 1500)), 1'b1, 1'b1);
        host_side_model_i.patchVal = host_side_model_i.mem[32'h7100];
        host_side_model_i.patchAddr = 32'h7100;
        host_side_model_i.patchOn = 1'b1;
        host_side_model_i.mem[32'h7100] = 32'h0;
        expR(32'h7100, DESC_WORDS);
        go(32'h7000, 4'(1 << CTRL_DYN), 1'b0);
        apb(1'b0, UNDERRUN_OFF, 32'h0);
        chk(rdat === 32'h1, "underrun counter");
        conclude();
    end
endmodule
